// ### bench/dtc_core_model.sv
// Processor-core model driving the special function register port
module dtc_core_model (
  input  wire logic       mclk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            look
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
    look      = 1'b0;
  end
  // Data is inverted once the strobe drops so a late sample cannot match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wr    <= 1'b1;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d;
  endtask
  // Read data stands in the cycle after the edge that samples the address
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    @(posedge mclk);
    look <= 1'b1;
    @(posedge mclk);
    look <= 1'b0;
  endtask
endmodule

// ### bench/dtc_timer_top_asserts.sv
// Concurrent checks on the timer block's register port, run bits and flags
module dtc_timer_top_asserts (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer0_vector_ack,
  input wire logic       timer1_vector_ack,
  input wire logic       timer0_overflow_flag,
  input wire logic       timer1_overflow_flag,
  input wire logic       timer0_run_bit,
  input wire logic       timer1_run_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_ctl;
  assign wr_ctl = sfr_wr && sfr_addr == 8'h88;
  sequence s_mode_wr; sfr_wr && sfr_addr == 8'h89; endsequence
  sequence s_mode_rd; !sfr_wr && sfr_addr == 8'h89; endsequence
  a_mode_readback: assert property (s_mode_wr ##1 s_mode_rd |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("mode readback wrong");
  a_run0_write: assert property (wr_ctl |=> timer0_run_bit == $past(sfr_wdata[4]))
    else $error("run bit 0 not written");
  a_run1_write: assert property (wr_ctl |=> timer1_run_bit == $past(sfr_wdata[6]))
    else $error("run bit 1 not written");
  a_ctrl_read: assert property (sfr_addr == 8'h88 |=> sfr_rdata == {$past(timer1_overflow_flag),
    $past(timer1_run_bit), $past(timer0_overflow_flag), $past(timer0_run_bit), 4'h0})
    else $error("control read wrong");
  // Flag lands one edge after the tick edge; the tick's run bit is the sample two edges back, but the check uses one
  a_flag0_cause: assert property ($rose(timer0_overflow_flag) |->
    $past(timer0_run_bit) || $past(wr_ctl && sfr_wdata[5])) else $error("flag 0 set without run");
  a_flag1_cause: assert property ($rose(timer1_overflow_flag) |->
    $past(timer1_run_bit) || $past(wr_ctl && sfr_wdata[7])) else $error("flag 1 set without run");
  a_flag0_clear: assert property ($fell(timer0_overflow_flag) |->
    $past(timer0_vector_ack) || $past(wr_ctl && !sfr_wdata[5])) else $error("flag 0 lost");
  a_flag1_clear: assert property ($fell(timer1_overflow_flag) |->
    $past(timer1_vector_ack) || $past(wr_ctl && !sfr_wdata[7])) else $error("flag 1 lost");
endmodule

bind dtc_timer_top dtc_timer_top_asserts u_chk (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_vector_ack(timer0_vector_ack),
  .timer1_vector_ack(timer1_vector_ack), .timer0_overflow_flag(timer0_overflow_flag),
  .timer1_overflow_flag(timer1_overflow_flag), .timer0_run_bit(timer0_run_bit), .timer1_run_bit(timer1_run_bit));

// ### bench/dtc_timer_top_tb.sv
// Self-checking testbench for the dual timer/counter block
module dtc_timer_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk;
  logic       rst_n;
  logic [1:0] cnt_pin;
  logic [1:0] ext_pin;
  logic [1:0] ack;
  logic [1:0] flags;
  logic [1:0] runs;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       look;
  logic [7:0] exp_q[$];
  int         n_mismatch;
  int         compares;

  dtc_core_model CORE (.mclk(mclk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .look(look));
  dtc_timer_top DUT (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer0_count_pin(cnt_pin[0]), .timer1_count_pin(cnt_pin[1]),
    .ext_interrupt0_pin(ext_pin[0]), .ext_interrupt1_pin(ext_pin[1]), .timer0_vector_ack(ack[0]),
    .timer1_vector_ack(ack[1]), .timer0_overflow_flag(flags[0]), .timer1_overflow_flag(flags[1]),
    .timer0_run_bit(runs[0]), .timer1_run_bit(runs[1]));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    CORE.rd(a);
  endtask
  always @(negedge mclk) if (look === 1'b1) chk(sfr_rdata, exp_q.pop_front());
  task automatic wait_flag(input int t, input int n);
    int i = 0;
    do begin
      @(posedge mclk);
      #1;
      i++;
    end while (flags[t] !== 1'b1 && i < n);
    chk({7'h00, flags[t]}, 8'h01);
    if (flags[t] !== 1'b1) stop_test();
  endtask
  task automatic quiet(input int t, input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      chk({7'h00, flags[t]}, 8'h00);
    end
  endtask
  task automatic arm(input int t, input logic [3:0] m, input logic [7:0] hi, input logic [7:0] lo);
    CORE.wr(8'h8C + 8'(t), hi);
    CORE.wr(8'h8A + 8'(t), lo);
    CORE.wr(8'h89, 8'(m) << (4 * t));
    CORE.wr(8'h88, 8'h10 << (2 * t));
  endtask
  // Stop the timer but keep its flag, then clear it through the vector acknowledge
  task automatic halt_clear(input int t, input logic [7:0] elo, input logic [7:0] ehi);
    CORE.wr(8'h88, 8'h20 << (2 * t));
    rd(8'h8A + 8'(t), elo);
    rd(8'h8C + 8'(t), ehi);
    rd(8'h88, 8'h20 << (2 * t));
    @(posedge mclk);
    ack[t] <= 1'b1;
    @(posedge mclk);
    ack[t] <= 1'b0;
    #1;
    chk({7'h00, flags[t]}, 8'h00);
  endtask
  task automatic chk_rst();
    for (int a = 8'h88; a <= 8'h8D; a++) rd(8'(a), 8'h00);
    rd(8'h90, 8'h00);
  endtask

  initial begin
    rst_n   = 1'b0;
    cnt_pin = 2'b11;
    ext_pin = 2'b00;
    ack     = 2'b00;
    void'($urandom(24));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk_rst();
    for (int a = 8'h8A; a <= 8'h8D; a++) begin
      logic [7:0] d;
      d = 8'($urandom);
      CORE.wr(8'(a), d);
      rd(8'(a), d);
    end
    for (int t = 0; t < 2; t++) begin
      arm(t, 4'h1, 8'hFF, 8'hFF);
      wait_flag(t, 20);
      halt_clear(t, 8'h00, 8'h00);
      arm(t, 4'h0, 8'hFF, 8'hFF);
      wait_flag(t, 20);
      halt_clear(t, 8'hE0, 8'h00);
      arm(t, 4'h2, 8'hF0, 8'hFE);
      wait_flag(t, 20);
      halt_clear(t, 8'hF0, 8'hF0);
      for (int k = 0; k < 2; k++) begin
        @(posedge mclk);
        ext_pin[t] <= 1'b0;
        arm(t, k ? 4'h5 : 4'h9, 8'hFF, 8'hFF);
        quiet(t, 20);
        @(posedge mclk);
        if (k) cnt_pin[t] <= 1'b0;
        else ext_pin[t] <= 1'b1;
        wait_flag(t, 12);
        halt_clear(t, 8'h00, 8'h00);
        cnt_pin[t] <= 1'b1;
      end
    end
    CORE.wr(8'h8B, 8'h55);
    // Load counts with both timers stopped so the low bytes hold still
    CORE.wr(8'h8C, 8'hFF);
    CORE.wr(8'h8A, 8'h77);
    CORE.wr(8'h89, 8'h33);
    CORE.wr(8'h88, 8'h40);
    wait_flag(1, 12);
    CORE.wr(8'h88, 8'h80);
    rd(8'h8C, 8'h00);
    rd(8'h8A, 8'h77);
    rd(8'h8B, 8'h55);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk_rst();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule

// ### src/dtc_cnt_if.sv
// Carrier between the top level and one timer count unit
interface dtc_cnt_if;
  logic               tick_lo;
  logic               tick_hi;
  dtc_pkg::dtc_mode_t mode;
  logic               wr_lo;
  logic               wr_hi;
  logic [7:0]         wdata;
  logic [7:0]         cnt_lo;
  logic [7:0]         cnt_hi;
  logic               ovf_lo;
  logic               ovf_hi;

  modport ctrl (output tick_lo, output tick_hi, output mode, output wr_lo, output wr_hi,
                output wdata, input cnt_lo, input cnt_hi, input ovf_lo, input ovf_hi);
  modport unit (input tick_lo, input tick_hi, input mode, input wr_lo, input wr_hi,
                input wdata, output cnt_lo, output cnt_hi, output ovf_lo, output ovf_hi);
endinterface

// ### src/dtc_count_unit.sv
// One timer's low and high count bytes with the four counting modes
module dtc_count_unit (
  input  wire logic mclk,
  input  wire logic rst_n,
  dtc_cnt_if.unit   cif
);

  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic       ovf_lo_q;
  logic       ovf_hi_q;

  assign cif.cnt_lo = lo_q;
  assign cif.cnt_hi = hi_q;
  assign cif.ovf_lo = ovf_lo_q;
  assign cif.ovf_hi = ovf_hi_q;

  // Software writes take priority over a tick in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q     <= dtc_pkg::RST_COUNT_BYTE;
      hi_q     <= dtc_pkg::RST_COUNT_BYTE;
      ovf_lo_q <= 1'b0;
      ovf_hi_q <= 1'b0;
    end else begin
      ovf_lo_q <= 1'b0;
      ovf_hi_q <= 1'b0;
      unique case (cif.mode)
        dtc_pkg::DTC_MODE_13BIT: begin
          if (cif.tick_lo) begin
            // Top three bits of the low byte are left alone
            lo_q[dtc_pkg::PRESCALE_BITS-1:0] <= lo_q[dtc_pkg::PRESCALE_BITS-1:0] + 5'h01;
            if (lo_q[dtc_pkg::PRESCALE_BITS-1:0] == dtc_pkg::PRESCALE_MAX) begin
              hi_q     <= hi_q + 8'h01;
              ovf_lo_q <= (hi_q == dtc_pkg::BYTE_MAX);
            end
          end
        end
        dtc_pkg::DTC_MODE_16BIT: begin
          if (cif.tick_lo) begin
            lo_q <= lo_q + 8'h01;
            if (lo_q == dtc_pkg::BYTE_MAX) begin
              hi_q     <= hi_q + 8'h01;
              ovf_lo_q <= (hi_q == dtc_pkg::BYTE_MAX);
            end
          end
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          if (cif.tick_lo) begin
            if (lo_q == dtc_pkg::BYTE_MAX) begin
              lo_q     <= hi_q;
              ovf_lo_q <= 1'b1;
            end else begin
              lo_q <= lo_q + 8'h01;
            end
          end
        end
        dtc_pkg::DTC_MODE_SPLIT: begin
          if (cif.tick_lo) begin
            lo_q     <= lo_q + 8'h01;
            ovf_lo_q <= (lo_q == dtc_pkg::BYTE_MAX);
          end
          if (cif.tick_hi) begin
            hi_q     <= hi_q + 8'h01;
            ovf_hi_q <= (hi_q == dtc_pkg::BYTE_MAX);
          end
        end
      endcase
      if (cif.wr_lo) begin
        lo_q <= cif.wdata;
      end
      if (cif.wr_hi) begin
        hi_q <= cif.wdata;
      end
    end
  end

endmodule

// ### src/dtc_pkg.sv
// Constants and types shared by the dual timer/counter block
// Operation
// - Timer 1 counts on run, gated by pin 1 (ignores its run bit while Timer 0 is in mode 11)
// - Timer 1 source: divided clock or pin falls
// - Timer 1 mode 00: 8-bit high, 5-bit prescaler
// - Timer 1 mode 01: cascaded 16-bit counter
// - Timer 1 mode 10: low byte reloads from high
// - Timer 1 mode 11: halted, holds its count
// - Timer 0 counts on run, gated by pin 0
// - Timer 0 source: divided clock or pin falls
// - Timer 0 mode 11: two independent 8-bit units
// - Count bytes clear to zero on reset
// - 13-bit mode ignores low byte's top three bits
// - Reload leaves the high byte unchanged
// - Overflow sets flag; vector acknowledge clears it
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_t;

  // Special function register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL_STATUS = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_CONTROL   = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_COUNT_LOW     = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_COUNT_LOW     = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH    = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH    = 8'h8D;

  // Mode control field positions
  localparam int MODE_T0_LSB        = 0;
  localparam int BIT_T0_SOURCE_SEL  = 2;
  localparam int BIT_T0_GATING      = 3;
  localparam int MODE_T1_LSB        = 4;
  localparam int BIT_T1_SOURCE_SEL  = 6;
  localparam int BIT_T1_GATING      = 7;

  // Control/status bit positions (external interrupt bits 3:0 live elsewhere)
  localparam int BIT_T0_RUN         = 4;
  localparam int BIT_T0_OVERFLOW    = 5;
  localparam int BIT_T1_RUN         = 6;
  localparam int BIT_T1_OVERFLOW    = 7;

  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNT_BYTE   = 8'h00;
  localparam logic [7:0] RST_READ_DATA    = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // Prescaler low-bit field for 13-bit mode
  localparam int         PRESCALE_BITS = 5;
  localparam logic [4:0] PRESCALE_MAX  = 5'h1F;
  localparam logic [7:0] BYTE_MAX      = 8'hFF;

  // System clock cycles per timer tick
  localparam int         TICK_DIV     = 6;
  localparam logic [3:0] TICK_DIV_MAX = 4'(TICK_DIV - 1);

endpackage

// ### src/dtc_timer_top.sv
// Dual timer/counter with mode control, reached over the special function register port
module dtc_timer_top (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer0_count_pin,
  input  wire logic       timer1_count_pin,
  input  wire logic       ext_interrupt0_pin,
  input  wire logic       ext_interrupt1_pin,
  input  wire logic       timer0_vector_ack,
  input  wire logic       timer1_vector_ack,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag,
  output logic            timer0_run_bit,
  output logic            timer1_run_bit
);

  dtc_cnt_if t0_if ();
  dtc_cnt_if t1_if ();

  logic [7:0] mode_ctl_q;
  logic       run0_q;
  logic       run1_q;
  logic       flag0_q;
  logic       flag1_q;
  logic [3:0] div_q;
  logic       t0_pin_q;
  logic       t1_pin_q;
  logic [7:0] rdata_q;

  logic       sys_tick;
  logic       t0_fall;
  logic       t1_fall;
  logic       en0;
  logic       en1;
  logic       t0_split;
  logic       ovf0_evt;
  logic       ovf1_evt;

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    sfr_hit = (addr == reg_addr);
  endfunction

  assign timer0_overflow_flag = flag0_q;
  assign timer1_overflow_flag = flag1_q;
  assign timer0_run_bit       = run0_q;
  assign timer1_run_bit       = run1_q;
  assign sfr_rdata            = rdata_q;

  // Divided-down system clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
    end else if (div_q == dtc_pkg::TICK_DIV_MAX) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
  assign sys_tick = (div_q == dtc_pkg::TICK_DIV_MAX);

  // Count pins are synchronous; remember last level for falling edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t0_pin_q <= 1'b1;
      t1_pin_q <= 1'b1;
    end else begin
      t0_pin_q <= timer0_count_pin;
      t1_pin_q <= timer1_count_pin;
    end
  end
  assign t0_fall = t0_pin_q & ~timer0_count_pin;
  assign t1_fall = t1_pin_q & ~timer1_count_pin;

  assign t0_split = (mode_ctl_q[dtc_pkg::MODE_T0_LSB+:2] == dtc_pkg::DTC_MODE_SPLIT);

  // Gating: run bit alone, or run bit and high interrupt pin
  assign en0 = run0_q & (~mode_ctl_q[dtc_pkg::BIT_T0_GATING] | ext_interrupt0_pin);
  // With Timer 0 split, Timer 1 loses its run bit to Timer 0's high byte and counts subject only to its gating
  assign en1 = (run1_q | t0_split) & (~mode_ctl_q[dtc_pkg::BIT_T1_GATING] | ext_interrupt1_pin);

  // Timer 0 unit
  assign t0_if.mode    = dtc_pkg::dtc_mode_t'(mode_ctl_q[dtc_pkg::MODE_T0_LSB+:2]);
  assign t0_if.tick_lo = en0 & (mode_ctl_q[dtc_pkg::BIT_T0_SOURCE_SEL] ? t0_fall : sys_tick);
  assign t0_if.tick_hi = run1_q & sys_tick;
  assign t0_if.wr_lo   = sfr_wr & sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER0_COUNT_LOW);
  assign t0_if.wr_hi   = sfr_wr & sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER0_COUNT_HIGH);
  assign t0_if.wdata   = sfr_wdata;

  // Timer 1 unit: mode 11 halts it by withholding ticks, whatever the run bit
  always_comb begin
    t1_if.mode    = dtc_pkg::dtc_mode_t'(mode_ctl_q[dtc_pkg::MODE_T1_LSB+:2]);
    t1_if.tick_lo = en1 & (mode_ctl_q[dtc_pkg::BIT_T1_SOURCE_SEL] ? t1_fall : sys_tick);
    t1_if.tick_hi = 1'b0;
    if (t1_if.mode == dtc_pkg::DTC_MODE_SPLIT) begin
      t1_if.tick_lo = 1'b0;
    end
  end
  assign t1_if.wr_lo = sfr_wr & sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER1_COUNT_LOW);
  assign t1_if.wr_hi = sfr_wr & sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER1_COUNT_HIGH);
  assign t1_if.wdata = sfr_wdata;

  dtc_count_unit u_timer0 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cif   (t0_if.unit)
  );

  dtc_count_unit u_timer1 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cif   (t1_if.unit)
  );

  // In split mode Timer 0's high byte owns the Timer 1 flag
  assign ovf0_evt = t0_if.ovf_lo;
  assign ovf1_evt = t0_split ? t0_if.ovf_hi : t1_if.ovf_lo;

  // Mode control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctl_q <= dtc_pkg::RST_MODE_CONTROL;
    end else if (sfr_wr && sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER_MODE_CONTROL)) begin
      mode_ctl_q <= sfr_wdata;
    end
  end

  // Run bits are software owned
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run0_q <= 1'b0;
      run1_q <= 1'b0;
    end else if (sfr_wr && sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER_CONTROL_STATUS)) begin
      run0_q <= sfr_wdata[dtc_pkg::BIT_T0_RUN];
      run1_q <= sfr_wdata[dtc_pkg::BIT_T1_RUN];
    end
  end

  // Overflow flags: an overflow in the clearing cycle still sets the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag0_q <= 1'b0;
      flag1_q <= 1'b0;
    end else begin
      if (ovf0_evt) begin
        flag0_q <= 1'b1;
      end else if (timer0_vector_ack) begin
        flag0_q <= 1'b0;
      end else if (sfr_wr && sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER_CONTROL_STATUS)) begin
        flag0_q <= sfr_wdata[dtc_pkg::BIT_T0_OVERFLOW];
      end
      if (ovf1_evt) begin
        flag1_q <= 1'b1;
      end else if (timer1_vector_ack) begin
        flag1_q <= 1'b0;
      end else if (sfr_wr && sfr_hit(sfr_addr, dtc_pkg::ADDR_TIMER_CONTROL_STATUS)) begin
        flag1_q <= sfr_wdata[dtc_pkg::BIT_T1_OVERFLOW];
      end
    end
  end

  // Registered read data, one cycle after the address is presented
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= dtc_pkg::RST_READ_DATA;
    end else begin
      unique case (sfr_addr)
        dtc_pkg::ADDR_TIMER_CONTROL_STATUS: begin
          rdata_q <= {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
        end
        dtc_pkg::ADDR_TIMER_MODE_CONTROL: begin
          rdata_q <= mode_ctl_q;
        end
        dtc_pkg::ADDR_TIMER0_COUNT_LOW: begin
          rdata_q <= t0_if.cnt_lo;
        end
        dtc_pkg::ADDR_TIMER1_COUNT_LOW: begin
          rdata_q <= t1_if.cnt_lo;
        end
        dtc_pkg::ADDR_TIMER0_COUNT_HIGH: begin
          rdata_q <= t0_if.cnt_hi;
        end
        dtc_pkg::ADDR_TIMER1_COUNT_HIGH: begin
          rdata_q <= t1_if.cnt_hi;
        end
        default: begin
          rdata_q <= dtc_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

endmodule
